// >>> rtl/lcp_map.svh
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH
// Root pointer and structure offsets
`define LCP_ROOT_DEFAULT 32'h00ff_fff4
`define LCP_SYSBUS_OFS_LE 32'h0000_0002
`define LCP_SYSBUS_OFS_BE 32'h0000_0001
`define LCP_ROOT_INTERMEDIATE_POINTER_OFS 32'h0000_0008
`define LCP_INTERMEDIATE_POINTER_BASE_OFS 32'h0000_0004
`define LCP_BUSY_SET 8'h01
`define LCP_BUSY_CLR 8'h00
// Sysbus byte fields
`define LCP_SB_BE32 7
`define LCP_SB_INTPOL 5
`define LCP_SB_LOCK 4
`define LCP_SB_TRIG 3
`define LCP_SB_MODE_HI 2
`define LCP_SB_MODE_LO 1
// Control block status word, command word cleared
`define LCP_SCB_DONE_WORD 32'h0000_a000
// Port function codes
`define LCP_FN_RESET 4'h0
`define LCP_FN_TEST 4'h1
`define LCP_FN_ROOT 4'h2
`define LCP_FN_DUMP 4'h3
`define LCP_TEST_PASS 32'h0000_0000
`define LCP_DUMP_WORDS 3'h5
// Throttle reset values
`define LCP_TON_RESET 16'hffff
`define LCP_TOFF_RESET 16'h0000
// Register port offsets
`define LCP_REG_STATUS 8'h00
`define LCP_REG_CTRL 8'h04
`define LCP_REG_SYSBUS 8'h08
`define LCP_REG_SCB 8'h0c
`define LCP_REG_ROOT 8'h10
`define LCP_CTRL_RESET 1'h1
`define LCP_SYNC_W 19
`endif

// >>> rtl/lcp_pkg.sv
package lcp_pkg;
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_SEG32 = 2'b01,
    MODE_LINEAR = 2'b10,
    MODE_RSVD = 2'b11
  } lcp_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SYSBUS = 4'b0001,
    ST_INTERMEDIATE_POINTER_PTR = 4'b0010,
    ST_INTERMEDIATE_POINTER_OFS = 4'b0011,
    ST_SCB_BASE = 4'b0100,
    ST_CLR_BUSY = 4'b0101,
    ST_SCB_STAT = 4'b0110,
    ST_TEST = 4'b0111,
    ST_DUMP = 4'b1000
  } lcp_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic byte_en;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lcp_mreq_s;

  typedef struct packed {
    logic [18:0] s1;
    logic [18:0] s2;
  } lcp_sync_s;

  typedef struct packed {
    lcp_state_e state;
    lcp_mode_e mode;
    logic [7:0] sysbus;
    logic need_init;
    logic half;
    logic halted;
    logic [15:0] port_lo;
    logic strobe_d;
    logic attn_d;
    logic [31:0] root;
    logic [31:0] intermediate_pointer;
    logic [15:0] scb_ofs;
    logic [31:0] scb_base;
    logic [31:0] op_addr;
    logic [2:0] dump_idx;
    lcp_mreq_s mreq;
    logic [15:0] ton;
    logic [15:0] toff;
    logic int_lvl;
    logic int_en;
    logic [31:0] rdata;
  } lcp_state_s;
endpackage : lcp_pkg

// >>> rtl/lcp_sync.sv
`timescale 1ns/10ps
`include "lcp_map.svh"
module lcp_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [`LCP_SYNC_W-1:0] async_in,
  output logic [`LCP_SYNC_W-1:0] sync_out
);
  lcp_pkg::lcp_sync_s s_r;
  lcp_pkg::lcp_sync_s s_nxt;

  always_comb begin
    s_nxt.s1 = async_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.s2;
endmodule : lcp_sync

// >>> rtl/lcp_init_port.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "lcp_map.svh"
// Behaviour
// - Byte order pin high means little-endian, low means big-endian.
// - Little-endian: sysbus byte read at root base plus two.
// - Big-endian: sysbus byte at 00FFFFF5h by default, else root base plus one.
// - Reserved sysbus bits ignored in legacy mode, written zero by host otherwise.
// - Host sets busy byte to 01h; device clears it after reading control block address.
// - Attention after reset starts init; sysbus options latched from root pointer.
// - After reset throttle on-time is infinite and off-time zero.
// - Intermediate pointer read next; control block address kept as base plus offset.
// - Finish: clear busy, set done and idle flags, clear command, interrupt, wait.
// - Port write carries address on bits 31..4, function on bits 3..0.
// - Function 0 reset, 1 self-test, 2 alternate root, 3 dump.
// - Two 16-bit port writes: first halts and captures, second captures and executes.
// - Dump writes internal state even when stuck; port reset reinitialises device only.
// - Self-test runs and stores its outcome at the given address.
// - Legacy mode: 24-bit linear addresses, top byte zero; 24-bit base plus offset.
// - 32-bit segmented mode: 32-bit linear addresses; 32-bit base plus offset.
// - Root pointer fetched from 00FFFFF4h unless an alternate was written.
// - Sysbus bit 7 enables true 32-bit big-endian pointers in linear mode.
// - Linear mode: every address absolute, no base plus offset.
module lcp_init_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic byte_order_select_in,
  input wire logic attention_strobe_in,
  input wire logic port_strobe_in,
  input wire logic [15:0] port_data_in,
  output lcp_pkg::lcp_mreq_s mem_req_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  output logic int_out,
  output logic lock_en_out,
  output logic throttle_trig_out,
  output logic [15:0] throttle_on_out,
  output logic [15:0] throttle_off_out,
  output logic [1:0] mode_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);
  lcp_pkg::lcp_state_s s_r;
  lcp_pkg::lcp_state_s s_nxt;
  logic [`LCP_SYNC_W-1:0] pins_sync;
  logic strobe_s;
  logic attn_s;
  logic order_le;
  logic [15:0] data_s;

  lcp_sync u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({port_strobe_in, attention_strobe_in, byte_order_select_in, port_data_in}),
    .sync_out(pins_sync)
  );

  assign strobe_s = pins_sync[18];
  assign attn_s = pins_sync[17];
  assign order_le = pins_sync[16];
  assign data_s = pins_sync[15:0];

  function automatic lcp_pkg::lcp_mreq_s issue(input logic we, input logic be,
                                               input logic [31:0] a, input logic [31:0] d);
    issue.req = 1'b1;
    issue.we = we;
    issue.byte_en = be;
    issue.addr = a;
    issue.wdata = d;
  endfunction : issue

  // Linear address width per mode
  function automatic logic [31:0] lin(input lcp_pkg::lcp_mode_e m, input logic [31:0] a);
    if (m == lcp_pkg::MODE_LEGACY) begin
      lin = {8'h00, a[23:0]};
    end else begin
      lin = a;
    end
  endfunction : lin

  // Base plus offset, or absolute in linear mode
  function automatic logic [31:0] form(input lcp_pkg::lcp_mode_e m, input logic [31:0] b,
                                       input logic [15:0] o);
    case (m)
      lcp_pkg::MODE_LEGACY: begin
        form = {8'h00, b[23:0] + {8'h00, o}};
      end
      lcp_pkg::MODE_SEG32: begin
        form = b + {16'h0000, o};
      end
      default: begin
        form = b;
      end
    endcase
  endfunction : form

  // Big-endian linear-mode pointers without bit 7 come as two 16-bit halves
  function automatic logic [31:0] fix_ptr(input logic le, input lcp_pkg::lcp_mode_e m,
                                          input logic be32, input logic [31:0] v);
    if (!le && m == lcp_pkg::MODE_LINEAR && !be32) begin
      fix_ptr = {v[15:0], v[31:16]};
    end else begin
      fix_ptr = v;
    end
  endfunction : fix_ptr

  // Dump area contents
  function automatic logic [31:0] dump_word(input lcp_pkg::lcp_state_s st, input logic [2:0] i);
    case (i)
      3'h0: begin
        dump_word = {20'h00000, st.state, st.sysbus};
      end
      3'h1: begin
        dump_word = st.root;
      end
      3'h2: begin
        dump_word = st.intermediate_pointer;
      end
      3'h3: begin
        dump_word = st.scb_base;
      end
      default: begin
        dump_word = {st.ton, st.scb_ofs};
      end
    endcase
  endfunction : dump_word

  function automatic lcp_pkg::lcp_mode_e lcp_lin_mode(input logic [7:0] b);
    lcp_lin_mode = lcp_pkg::lcp_mode_e'(b[`LCP_SB_MODE_HI:`LCP_SB_MODE_LO]);
  endfunction : lcp_lin_mode

  always_comb begin
    logic [31:0] word;
    logic [31:0] area;
    logic [7:0] sb;
    lcp_pkg::lcp_mode_e m;
    logic step;
    word = {data_s, s_r.port_lo};
    area = {word[31:4], 4'h0};
    sb = mem_rdata_in[7:0];
    m = lcp_lin_mode(sb);
    s_nxt = s_r;
    s_nxt.strobe_d = strobe_s;
    s_nxt.attn_d = attn_s;
    s_nxt.int_lvl = s_r.sysbus[`LCP_SB_INTPOL] ? 1'b0 : 1'b1;
    s_nxt.rdata = 32'h0000_0000;
    step = s_r.mreq.req && mem_ack_in && !s_r.halted;
    if (step) begin
      s_nxt.mreq.req = 1'b0;
    end

    case (s_r.state)
      lcp_pkg::ST_IDLE: begin
        if (attn_s && !s_r.attn_d && s_r.need_init && !s_r.halted) begin
          s_nxt.state = lcp_pkg::ST_SYSBUS;
          s_nxt.mreq = issue(1'b0, 1'b1, s_r.root + (order_le ? `LCP_SYSBUS_OFS_LE
                                                              : `LCP_SYSBUS_OFS_BE), 32'h0);
        end
      end
      lcp_pkg::ST_SYSBUS: begin
        if (step) begin
          s_nxt.mode = m;
          s_nxt.sysbus = (m == lcp_pkg::MODE_LEGACY) ? 8'h00 : sb;
          s_nxt.state = lcp_pkg::ST_INTERMEDIATE_POINTER_PTR;
          s_nxt.mreq = issue(1'b0, 1'b0, lin(m, s_r.root + `LCP_ROOT_INTERMEDIATE_POINTER_OFS), 32'h0);
        end
      end
      lcp_pkg::ST_INTERMEDIATE_POINTER_PTR: begin
        if (step) begin
          s_nxt.intermediate_pointer = lin(s_r.mode, fix_ptr(order_le, s_r.mode, s_r.sysbus[`LCP_SB_BE32],
                                             mem_rdata_in));
          s_nxt.state = lcp_pkg::ST_INTERMEDIATE_POINTER_OFS;
          s_nxt.mreq = issue(1'b0, 1'b0, s_nxt.intermediate_pointer, 32'h0);
        end
      end
      lcp_pkg::ST_INTERMEDIATE_POINTER_OFS: begin
        if (step) begin
          s_nxt.scb_ofs = (s_r.mode == lcp_pkg::MODE_LINEAR) ? 16'h0000 : mem_rdata_in[31:16];
          s_nxt.state = lcp_pkg::ST_SCB_BASE;
          s_nxt.mreq = issue(1'b0, 1'b0, lin(s_r.mode, s_r.intermediate_pointer + `LCP_INTERMEDIATE_POINTER_BASE_OFS), 32'h0);
        end
      end
      lcp_pkg::ST_SCB_BASE: begin
        if (step) begin
          s_nxt.scb_base = lin(s_r.mode, fix_ptr(order_le, s_r.mode, s_r.sysbus[`LCP_SB_BE32],
                                                 mem_rdata_in));
          s_nxt.state = lcp_pkg::ST_CLR_BUSY;
          s_nxt.mreq = issue(1'b1, 1'b1, s_r.intermediate_pointer, {24'h000000, `LCP_BUSY_CLR});
        end
      end
      lcp_pkg::ST_CLR_BUSY: begin
        if (step) begin
          s_nxt.state = lcp_pkg::ST_SCB_STAT;
          s_nxt.mreq = issue(1'b1, 1'b0, form(s_r.mode, s_r.scb_base, s_r.scb_ofs),
                             `LCP_SCB_DONE_WORD);
        end
      end
      lcp_pkg::ST_SCB_STAT: begin
        if (step) begin
          s_nxt.need_init = 1'b0;
          s_nxt.state = lcp_pkg::ST_IDLE;
          if (s_r.int_en) begin
            s_nxt.int_lvl = s_r.sysbus[`LCP_SB_INTPOL] ? 1'b1 : 1'b0;
          end
        end
      end
      lcp_pkg::ST_TEST: begin
        if (step) begin
          s_nxt.state = lcp_pkg::ST_IDLE;
        end
      end
      lcp_pkg::ST_DUMP: begin
        if (step) begin
          if (s_r.dump_idx == `LCP_DUMP_WORDS - 3'h1) begin
            s_nxt.state = lcp_pkg::ST_IDLE;
          end else begin
            s_nxt.dump_idx = s_r.dump_idx + 3'h1;
            s_nxt.mreq = issue(1'b1, 1'b0, s_r.op_addr + {27'h0, s_nxt.dump_idx, 2'b00},
                               dump_word(s_r, s_nxt.dump_idx));
          end
        end
      end
      default: begin
        s_nxt.state = lcp_pkg::ST_IDLE;
      end
    endcase

    // Port access, two halves
    if (strobe_s && !s_r.strobe_d) begin
      if (!s_r.half) begin
        s_nxt.port_lo = data_s;
        s_nxt.half = 1'b1;
        s_nxt.halted = 1'b1;
        s_nxt.mreq.req = 1'b0;
      end else begin
        s_nxt.half = 1'b0;
        s_nxt.halted = 1'b0;
        s_nxt.dump_idx = 3'h0;
        s_nxt.op_addr = area;
        s_nxt.state = lcp_pkg::ST_IDLE;
        s_nxt.mreq.req = 1'b0;
        case (word[3:0])
          `LCP_FN_RESET: begin
            s_nxt.need_init = 1'b1;
            s_nxt.mode = lcp_pkg::MODE_LEGACY;
            s_nxt.sysbus = 8'h00;
            s_nxt.ton = `LCP_TON_RESET;
            s_nxt.toff = `LCP_TOFF_RESET;
          end
          `LCP_FN_TEST: begin
            s_nxt.state = lcp_pkg::ST_TEST;
            s_nxt.mreq = issue(1'b1, 1'b0, area, `LCP_TEST_PASS);
          end
          `LCP_FN_ROOT: begin
            s_nxt.root = area;
          end
          `LCP_FN_DUMP: begin
            s_nxt.state = lcp_pkg::ST_DUMP;
            s_nxt.mreq = issue(1'b1, 1'b0, area, dump_word(s_r, 3'h0));
          end
          default: begin
            s_nxt.state = s_r.state;
            s_nxt.mreq = s_r.mreq;
          end
        endcase
      end
    end

    // Register port
    if (reg_wr_in && reg_addr_in == `LCP_REG_CTRL) begin
      s_nxt.int_en = reg_wdata_in[0];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `LCP_REG_STATUS: begin
          s_nxt.rdata = {22'h0, s_r.mode, s_r.state, s_r.need_init, s_r.halted, s_r.half,
                         order_le};
        end
        `LCP_REG_CTRL: begin
          s_nxt.rdata = {31'h0, s_r.int_en};
        end
        `LCP_REG_SYSBUS: begin
          s_nxt.rdata = {24'h0, s_r.sysbus};
        end
        `LCP_REG_SCB: begin
          s_nxt.rdata = form(s_r.mode, s_r.scb_base, s_r.scb_ofs);
        end
        `LCP_REG_ROOT: begin
          s_nxt.rdata = s_r.root;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.state <= lcp_pkg::ST_IDLE;
      s_r.mode <= lcp_pkg::MODE_LEGACY;
      s_r.need_init <= 1'b1;
      s_r.root <= `LCP_ROOT_DEFAULT;
      s_r.ton <= `LCP_TON_RESET;
      s_r.toff <= `LCP_TOFF_RESET;
      s_r.int_en <= `LCP_CTRL_RESET;
      s_r.int_lvl <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_req_out = s_r.mreq;
  assign int_out = s_r.int_lvl;
  assign lock_en_out = s_r.sysbus[`LCP_SB_LOCK];
  assign throttle_trig_out = s_r.sysbus[`LCP_SB_TRIG];
  assign throttle_on_out = s_r.ton;
  assign throttle_off_out = s_r.toff;
  assign mode_out = s_r.mode;
  assign reg_rdata_out = s_r.rdata;
endmodule : lcp_init_port

// >>> testbench/lcp_init_port_props.sv
`timescale 1ns/10ps
module lcp_init_port_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic byte_order_select_in,
  input wire lcp_pkg::lcp_mreq_s mem_req_out,
  input wire logic mem_ack_in,
  input wire logic int_out,
  input wire logic [15:0] throttle_on_out,
  input wire logic [15:0] throttle_off_out,
  input wire logic [1:0] mode_out
);
  logic [31:0] sb_addr_r;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence sysbus_rd;
    mem_req_out.req && mem_ack_in && !mem_req_out.we && mem_req_out.byte_en;
  endsequence
  sequence busy_wr;
    mem_req_out.req && mem_ack_in && mem_req_out.we && mem_req_out.byte_en;
  endsequence
  sequence done_wr;
    mem_req_out.req && mem_ack_in && mem_req_out.we && mem_req_out.wdata == 32'h0000_a000;
  endsequence

  // Address of the last byte read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sb_addr_r <= 32'h0000_0000;
    end else if (mem_req_out.req && !mem_req_out.we && mem_req_out.byte_en) begin
      sb_addr_r <= mem_req_out.addr;
    end
  end

  thr_idle_a: assert property (throttle_on_out == 16'hffff && throttle_off_out == 16'h0000)
    else $error("throttle timers not disabled");
  mreq_hold_a: assert property (mem_req_out.req && !mem_ack_in |=> mem_req_out.req &&
    $stable(mem_req_out.addr) && $stable(mem_req_out.we) && $stable(mem_req_out.wdata))
    else $error("memory request changed before ack");
  sysbus_loc_a: assert property (mem_req_out.req && !mem_req_out.we && mem_req_out.byte_en |->
    mem_req_out.addr[1:0] == (byte_order_select_in ? 2'h2 : 2'h1))
    else $error("sysbus byte fetched at wrong offset");
  root_next_a: assert property (sysbus_rd |-> ##[1:3] (mem_req_out.req && !mem_req_out.we &&
    mem_req_out.addr == sb_addr_r + (byte_order_select_in ? 32'h6 : 32'h7)))
    else $error("pointer dword not read after sysbus");
  busy_clr_a: assert property (mem_req_out.req && mem_req_out.we && mem_req_out.byte_en |->
    mem_req_out.wdata[7:0] == 8'h00)
    else $error("busy byte not cleared to zero");
  done_word_a: assert property (busy_wr |-> ##[1:3] (mem_req_out.req && mem_req_out.we &&
    !mem_req_out.byte_en && mem_req_out.wdata == 32'h0000_a000))
    else $error("status word not written after busy clear");
  int_after_a: assert property (done_wr |-> ##[1:4] !int_out)
    else $error("no interrupt after init finish");
  int_pulse_a: assert property ($fell(int_out) |=> int_out)
    else $error("interrupt pulse longer than one cycle");
  legacy_addr_a: assert property (mem_req_out.req && mode_out == 2'b00 |->
    mem_req_out.addr[31:24] == 8'h00)
    else $error("legacy address top byte not zero");
  mode_legal_a: assert property (mode_out != 2'b11)
    else $error("reserved mode latched");
endmodule : lcp_init_port_props

bind lcp_init_port lcp_init_port_props i_props (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .byte_order_select_in(byte_order_select_in),
  .mem_req_out(mem_req_out),
  .mem_ack_in(mem_ack_in),
  .int_out(int_out),
  .throttle_on_out(throttle_on_out),
  .throttle_off_out(throttle_off_out),
  .mode_out(mode_out)
);

// >>> testbench/lcp_mem_model.sv
`timescale 1ns/10ps
module lcp_mem_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_in,
  input wire lcp_pkg::lcp_mreq_s mem_req_in,
  output logic mem_ack_out,
  output logic [31:0] mem_rdata_out
);
  logic [7:0] mem [bit [31:0]];
  int wait_cnt = 0;
  int wr_count = 0;

  function automatic logic [31:0] rd32(input logic [31:0] a);
    return {mem[a + 32'h3], mem[a + 32'h2], mem[a + 32'h1], mem[a]};
  endfunction : rd32

  task automatic put32(input logic [31:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      mem[a + i] = d[8 * i +: 8];
    end
  endtask : put32

  // Ack after 0 or 3 wait cycles; data bus toggles when not answering
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 32'h5a5a_a5a5;
      wait_cnt <= 0;
    end else if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      wait_cnt <= 0;
    end else if (mem_req_in.req && wait_cnt >= (slow_in ? 3 : 0)) begin
      mem_ack_out <= 1'b1;
      if (!mem_req_in.we) begin
        mem_rdata_out <= mem_req_in.byte_en ? {24'h0, mem[mem_req_in.addr]} : rd32(mem_req_in.addr);
      end else if (mem_req_in.byte_en) begin
        mem[mem_req_in.addr] = mem_req_in.wdata[7:0];
        wr_count <= wr_count + 1;
      end else begin
        put32(mem_req_in.addr, mem_req_in.wdata);
        wr_count <= wr_count + 1;
      end
    end else begin
      wait_cnt <= mem_req_in.req ? wait_cnt + 1 : 0;
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : lcp_mem_model

// >>> testbench/lcp_init_port_tb_top.sv
`timescale 1ns/10ps
module lcp_init_port_tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic le = 1'b1;
  logic attn = 1'b0;
  logic pstb = 1'b0;
  logic slow = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] pdata = 16'h0000;
  logic [7:0] raddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_001c;
  lcp_pkg::lcp_mreq_s mreq;
  logic ack, int_o, lock_o, trig_o;
  logic [31:0] mrdata, rdata, v, root, area;
  logic [15:0] ton, toff;
  logic [1:0] mode;
  int err_total = 0;
  int check_count = 0;
  int w0;
  int k;

  always #5 clk_in = ~clk_in;

  lcp_init_port i_dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .byte_order_select_in(le),
    .attention_strobe_in(attn),
    .port_strobe_in(pstb),
    .port_data_in(pdata),
    .mem_req_out(mreq),
    .mem_ack_in(ack),
    .mem_rdata_in(mrdata),
    .int_out(int_o),
    .lock_en_out(lock_o),
    .throttle_trig_out(trig_o),
    .throttle_on_out(ton),
    .throttle_off_out(toff),
    .mode_out(mode),
    .reg_addr_in(raddr),
    .reg_wdata_in(wdata),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata)
  );

  lcp_mem_model i_mem (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .slow_in(slow),
    .mem_req_in(mreq),
    .mem_ack_out(ack),
    .mem_rdata_out(mrdata)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] scb_exp(input logic [1:0] m, input logic [15:0] o, input logic [31:0] b);
    if (m == 2'b10) begin
      return b;
    end
    if (m == 2'b01) begin
      return b + {16'h0, o};
    end
    return (b + {16'h0, o}) & 32'h00ff_ffff;
  endfunction : scb_exp

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    raddr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    raddr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
  endtask : reg_wr

  // Low half first, then high half
  task automatic port_cmd(input logic [31:0] w);
    for (int h = 0; h < 2; h++) begin
      pdata <= w[16 * h +: 16];
      cyc(2);
      pstb <= 1'b1;
      cyc(4);
      pstb <= 1'b0;
    end
    cyc(6);
  endtask : port_cmd

  task automatic wait_wr(input int n);
    int t;
    t = 0;
    while (i_mem.wr_count < n && t < 500) begin
      cyc(1);
      t++;
    end
    chk("write_count", n, i_mem.wr_count);
  endtask : wait_wr

  task automatic do_init(input logic bo, input logic [31:0] rt, input logic [1:0] m);
    logic [31:0] intermediate_pointer, base, r;
    logic [15:0] ofs;
    logic [7:0] sb;
    r = xs();
    intermediate_pointer = 32'h0020_0000 | (r & 32'h000f_fff0);
    ofs = {r[31:18], 2'b00};
    sb = {3'b000, r[4:3], m, 1'b0};
    r = xs();
    base = {r[31:24], 8'h30, r[15:2], 2'b00};
    i_mem.mem[rt + (bo ? 32'h2 : 32'h1)] = sb;
    i_mem.mem[rt + (bo ? 32'h1 : 32'h2)] = sb ^ 8'h02;
    i_mem.put32(rt + 32'h8, intermediate_pointer);
    i_mem.put32(intermediate_pointer, {ofs, 16'h0001});
    i_mem.put32(intermediate_pointer + 32'h4, base);
    le <= bo;
    cyc(4);
    w0 = i_mem.wr_count;
    attn <= 1'b1;
    cyc(4);
    attn <= 1'b0;
    wait_wr(w0 + 2);
    repeat (8) if (int_o !== 1'b0) cyc(1);
    chk("int_pulse", 32'h0, int_o);
    chk("mode", m, mode);
    chk("lock", (m == 2'b00) ? 1'b0 : sb[4], lock_o);
    chk("trigger", (m == 2'b00) ? 1'b0 : sb[3], trig_o);
    chk("busy", 32'h0, i_mem.mem[intermediate_pointer]);
    chk("scb_word", 32'h0000_a000, i_mem.rd32(scb_exp(m, ofs, base)));
    reg_rd(8'h08, r);
    chk("sysbus_reg", (m == 2'b00) ? 32'h0 : {24'h0, sb}, r);
    reg_rd(8'h0c, r);
    chk("scb_addr", scb_exp(m, ofs, base), r);
  endtask : do_init

  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Whole sequence needs about 2k cycles
  initial begin
    cyc(50000);
    err_total++;
    print_verdict();
  end

  initial begin
    cyc(5);
    rst_b_in <= 1'b1;
    cyc(2);
    reg_rd(8'h10, v);
    chk("root_reset", 32'h00ff_fff4, v);
    reg_rd(8'h04, v);
    chk("ctrl_reset", 32'h1, v);
    reg_wr(8'h04, 32'h0);
    reg_rd(8'h04, v);
    chk("ctrl_write", 32'h0, v);
    reg_wr(8'h04, 32'h1);
    reg_rd(8'h44, v);
    chk("unmapped", 32'h0, v);
    do_init(1'b1, 32'h00ff_fff4, 2'b10);
    for (int i = 0; i < 10; i++) begin
      v = xs();
      slow <= v[8];
      root = 32'h0010_0000 | (v & 32'h000f_fff0);
      area = root ^ 32'h0008_0000;
      port_cmd(root | 32'h2);
      reg_rd(8'h10, v);
      chk("alt_root", root, v);
      port_cmd(32'h0);
      chk("mode_reset", 32'h0, mode);
      cyc(12);
      k = i % 5;
      do_init(k < 3, root, 2'(k < 3 ? k : k - 3));
      i_mem.put32(area, 32'hffff_ffff);
      w0 = i_mem.wr_count;
      port_cmd(area | 32'h1);
      wait_wr(w0 + 1);
      chk("self_test", 32'h0, i_mem.rd32(area));
      port_cmd(area | 32'h3);
      wait_wr(w0 + 6);
      chk("dump_root", root, i_mem.rd32(area + 32'h4));
      port_cmd(area | 32'h4);
      reg_rd(8'h10, v);
      chk("root_kept", root, v);
    end
    print_verdict();
  end
endmodule : lcp_init_port_tb_top
